// ---- logic/fuse_ctrl_pkg.sv ----
// constants, field positions, region table and state type of the fuse controller
// assumes one 100 MHz clock and a plain word-wide register port
// Functional notes
// - 1024 fuse bits as 128 bytes, 7-bit byte address n selects byte n.
// - programming only sets bits; a burned 1 never returns to 0.
// - software reaches fuse bytes only through controller registers.
// - after every reset all fuse bytes are read into their registers.
// - bytes 0..3 and reserved 4..15 reprogrammable, loaded at reset, readable.
// - 16-byte key at 16 programmable once, loaded at reset, readable.
// - 32-byte trust anchor at 32 programmable once, readable by boot ROM only.
// - 16-byte unique identifier at 64 not programmable, loaded, readable.
// - 16-byte hardware unique key at 80 not programmable, loaded, readable.
// - 32-byte user data at 96 programmable once per reset, loaded, readable.
// - burned data comes from the data registers loaded before start.
// - finished read sets read-done flag; interrupt when enabled.
// - finished program sets program-done flag; interrupt when enabled.
// - program not matching a parameter boundary sets boundary-error flag.
// - software sets start; hardware clears it at end; writing 0 does nothing.
// - direction 0 read, 1 write; frozen while start is 1.
// - size in bits 13:8, address in bits 6:0; frozen while start is 1.
// - writing 1 to a clear bit clears its flag; 0 has no effect.
package fuse_ctrl_pkg;
    localparam int unsigned CLK_MHZ      = 100;
    localparam int unsigned FUSE_BYTES   = 128;
    localparam int unsigned BUS_AW       = 12;
    // register offsets
    localparam logic [11:0] CS_OFF       = 12'h000;
    localparam logic [11:0] ADDR_OFF     = 12'h004;
    localparam logic [3:0]  DATA_PAGE    = 4'h1;
    localparam logic [31:0] CS_RST       = 32'h0000_0000;
    localparam logic [31:0] ADDR_RST     = 32'h0000_0000;
    // control and status fields
    localparam int unsigned START_BIT    = 0;
    localparam int unsigned DIR_BIT      = 1;
    localparam int unsigned PG_FLAG_BIT  = 16;
    localparam int unsigned RD_FLAG_BIT  = 17;
    localparam int unsigned BE_FLAG_BIT  = 18;
    localparam int unsigned PG_IE_BIT    = 20;
    localparam int unsigned RD_IE_BIT    = 21;
    localparam int unsigned BE_IE_BIT    = 22;
    localparam int unsigned PG_CLR_BIT   = 24;
    localparam int unsigned RD_CLR_BIT   = 25;
    localparam int unsigned BE_CLR_BIT   = 26;
    // address register fields
    localparam int unsigned SADDR_LSB    = 0;
    localparam int unsigned SIZE_LSB     = 8;
    // burn time of one byte, least time, rounded up
    localparam int unsigned PROG_TIME_NS = 1000;
    localparam int unsigned PROG_CYCLES  = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    // parameter regions
    localparam int unsigned NUM_REGIONS  = 10;
    localparam int unsigned RG_KEY       = 5;
    localparam int unsigned RG_ANCHOR    = 6;
    localparam int unsigned RG_UID       = 7;
    localparam int unsigned RG_HUK       = 8;
    localparam int unsigned RG_USER      = 9;
    localparam logic [6:0] RG_START [NUM_REGIONS] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04,
                                                      7'h10, 7'h20, 7'h40, 7'h50, 7'h60};
    localparam logic [5:0] RG_WIDTH [NUM_REGIONS] = '{6'h01, 6'h01, 6'h01, 6'h01, 6'h0C,
                                                      6'h10, 6'h20, 6'h10, 6'h10, 6'h20};
    localparam logic [2:0] ANCHOR_WORD_HI = 3'h1;
    localparam logic [7:0] BYTE_LIMIT     = 8'h80;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_IDLE = 2'b01,
        ST_READ = 2'b10,
        ST_PROG = 2'b11
    } state_t;
endpackage

// ---- logic/region_match.sv ----
// boundary match of one parameter region
// assumes address and size come from the frozen address register
`timescale 1ns/10ps
module region_match #(
    parameter logic [6:0] START = 7'h00,
    parameter logic [5:0] WIDTH = 6'h01
) (
    // request
    input  wire logic [6:0] addr,
    input  wire logic [5:0] size,
    // result
    output      logic       hit
);
    assign hit = (addr == START) && (size == WIDTH);
endmodule

// ---- logic/fuse_macro_wrapper.sv ----
// one-time-programmable array model, one byte per access
// assumes requests arrive only while no access is active
`timescale 1ns/10ps
module fuse_macro_wrapper (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       blank_array,
    // access
    input  wire logic       req,
    input  wire logic       we,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] wdata,
    output      logic [7:0] rdata,
    output      logic       done
);
    logic [7:0]  cells [fuse_ctrl_pkg::FUSE_BYTES];
    logic        act_q;
    logic        we_q;
    logic [6:0]  a_q;
    logic [7:0]  d_q;
    logic [15:0] cnt_q;

    // access sequencing; reset does not touch the cells
    always_ff @(posedge clk) begin
        if (rst) begin
            act_q <= 1'b0;
            done  <= 1'b0;
            rdata <= 8'h00;
            we_q  <= 1'b0;
            a_q   <= 7'h00;
            d_q   <= 8'h00;
            cnt_q <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (req && !act_q) begin
                act_q <= 1'b1;
                we_q  <= we;
                a_q   <= addr;
                d_q   <= wdata;
                cnt_q <= we ? 16'(fuse_ctrl_pkg::PROG_CYCLES - 1) : 16'h0000;
            end else if (act_q) begin
                if (cnt_q == 16'h0000) begin
                    act_q <= 1'b0;
                    done  <= 1'b1;
                    rdata <= cells[a_q] | (we_q ? d_q : 8'h00);
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
        end
    end

    // blank silicon model; cells only gain ones
    always_ff @(posedge clk) begin
        if (blank_array) begin
            for (int i = 0; i < fuse_ctrl_pkg::FUSE_BYTES; i++) begin
                cells[i] <= 8'h00;
            end
        end else if (act_q && we_q && cnt_q == 16'h0000) begin
            cells[a_q] <= cells[a_q] | d_q;
        end
    end
endmodule

// ---- logic/efuse_read_program_controller.sv ----
// fuse controller: register port, reset reload, read and program sequencing
// assumes the register master drives one-cycle strobes synchronous to clk
// assumes blank_array is only used by simulation to start from virgin cells
// map: 0x000 control and status, 0x004 address and size, 0x100..0x17C data words
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module efuse_read_program_controller (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        blank_array,
    // register port
    input  wire logic [11:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output      logic [31:0] rdata,
    // boot rom port
    input  wire logic [6:0]  rom_addr,
    output      logic [7:0]  rom_data,
    // interrupt
    output      logic        irq
);
    fuse_ctrl_pkg::state_t state_q;

    logic       operation_start_q;
    logic       operation_direction_q;
    logic [5:0] transfer_size_q;
    logic [6:0] transfer_start_address_q;
    logic       read_done_flag_q;
    logic       program_done_flag_q;
    logic       boundary_error_flag_q;
    logic       read_done_irq_enable_q;
    logic       program_done_irq_enable_q;
    logic       boundary_error_irq_enable_q;
    logic       key_used_q;
    logic       anchor_used_q;
    logic       user_done_q;
    logic [7:0] shadow [fuse_ctrl_pkg::FUSE_BYTES];
    logic [6:0] idx_q;
    logic [5:0] left_q;
    logic       pend_q;

    logic       wr_cs;
    logic       wr_addr;
    logic       data_sel;
    logic       wr_data;
    logic [4:0] word;
    logic [2:0] mac_ctl;
    logic       mac_req;
    logic       mac_done;
    logic [7:0] mac_rdata;
    logic       launch;
    logic       chk_err;
    logic       op_last;
    logic       finish;
    logic       set_rd;
    logic       set_pg;
    logic       set_be;
    logic [fuse_ctrl_pkg::NUM_REGIONS-1:0] hit;
    logic       prog_ok;
    logic [7:0] end_addr;

    // register decode
    assign word     = addr[6:2];
    assign data_sel = (addr[11:8] == fuse_ctrl_pkg::DATA_PAGE) && !addr[7] && (addr[1:0] == 2'b00);
    assign wr_cs    = wr_en && (addr == fuse_ctrl_pkg::CS_OFF);
    assign wr_addr  = wr_en && (addr == fuse_ctrl_pkg::ADDR_OFF);
    // data registers frozen during any sequence
    assign wr_data  = wr_en && data_sel && !operation_start_q && (state_q == fuse_ctrl_pkg::ST_IDLE);

    // boundary table
    for (genvar g = 0; g < fuse_ctrl_pkg::NUM_REGIONS; g++) begin : g_rg
        region_match #(
            .START (fuse_ctrl_pkg::RG_START[g]),
            .WIDTH (fuse_ctrl_pkg::RG_WIDTH[g])
        ) u_rg (
            .addr (transfer_start_address_q),
            .size (transfer_size_q),
            .hit  (hit[g])
        );
    end

    // program permission per region
    // small regions below the key are always open; bits only ever gain ones
    // identifier and hardware key regions never appear here, so they refuse
    // the key or anchor region that holds any burned bit at reload stays locked
    always_comb begin
        prog_ok = |hit[fuse_ctrl_pkg::RG_KEY-1:0];
        if (hit[fuse_ctrl_pkg::RG_KEY] && !key_used_q) begin
            prog_ok = 1'b1;
        end
        if (hit[fuse_ctrl_pkg::RG_ANCHOR] && !anchor_used_q) begin
            prog_ok = 1'b1;
        end
        if (hit[fuse_ctrl_pkg::RG_USER] && !user_done_q) begin
            prog_ok = 1'b1;
        end
    end

    // reads must stay inside the 128 bytes
    assign end_addr = {1'b0, transfer_start_address_q} + {2'b00, transfer_size_q};
    // error decided before any macro access
    assign chk_err  = operation_direction_q ? !prog_ok
                    : ((transfer_size_q == 6'h00) || (end_addr > fuse_ctrl_pkg::BYTE_LIMIT));
    assign launch   = (state_q == fuse_ctrl_pkg::ST_IDLE) && operation_start_q;
    assign op_last  = mac_done && (left_q == 6'h01)
                    && ((state_q == fuse_ctrl_pkg::ST_READ) || (state_q == fuse_ctrl_pkg::ST_PROG));
    assign set_be   = launch && chk_err;
    assign set_rd   = op_last && (state_q == fuse_ctrl_pkg::ST_READ);
    assign set_pg   = op_last && (state_q == fuse_ctrl_pkg::ST_PROG);
    assign finish   = set_be || op_last;
    // one macro access in flight: pend_q blocks a second request until done
    // returns, so each byte costs request, access and write-back cycles
    assign mac_req  = !pend_q && (state_q != fuse_ctrl_pkg::ST_IDLE);

    // macro access request fields
    assign mac_ctl  = {mac_req, state_q == fuse_ctrl_pkg::ST_PROG, 1'b0};

    // cells reached only through this sequencer
    fuse_macro_wrapper u_macro (
        .clk         (clk),
        .rst         (rst),
        .blank_array (blank_array),
        .req         (mac_ctl[2]),
        .we          (mac_ctl[1]),
        .addr        (idx_q),
        .wdata       (shadow[idx_q]),
        .rdata       (mac_rdata),
        .done        (mac_done)
    );

    // sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= fuse_ctrl_pkg::ST_LOAD;
            idx_q   <= 7'h00;
            left_q  <= 6'h00;
            pend_q  <= 1'b0;
        end else begin
            if (mac_req) begin
                pend_q <= 1'b1;
            end else if (mac_done) begin
                pend_q <= 1'b0;
            end
            unique case (state_q)
                fuse_ctrl_pkg::ST_LOAD: begin
                    if (mac_done) begin
                        idx_q <= idx_q + 7'h01;
                        if (idx_q == 7'h7F) begin
                            state_q <= fuse_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
                fuse_ctrl_pkg::ST_IDLE: begin
                    if (launch && !chk_err) begin
                        idx_q   <= transfer_start_address_q;
                        left_q  <= transfer_size_q;
                        state_q <= operation_direction_q ? fuse_ctrl_pkg::ST_PROG : fuse_ctrl_pkg::ST_READ;
                    end
                end
                fuse_ctrl_pkg::ST_READ,
                fuse_ctrl_pkg::ST_PROG: begin
                    if (mac_done) begin
                        idx_q  <= idx_q + 7'h01;
                        left_q <= left_q - 6'h01;
                        if (left_q == 6'h01) begin
                            state_q <= fuse_ctrl_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // data registers: filled from the array, or by software before a program
    // the macro write-back wins over a bus write; software writes during a
    // sequence are refused anyway, so nothing is lost
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < fuse_ctrl_pkg::FUSE_BYTES; i++) begin
                shadow[i] <= 8'h00;
            end
        end else if (mac_done && state_q != fuse_ctrl_pkg::ST_IDLE) begin
            shadow[idx_q] <= mac_rdata;
        end else if (wr_data) begin
            for (int b = 0; b < 4; b++) begin
                shadow[{word, 2'(b)}] <= wdata[8*b +: 8];
            end
        end
    end

    // once-only tracking
    always_ff @(posedge clk) begin
        if (rst) begin
            key_used_q    <= 1'b0;
            anchor_used_q <= 1'b0;
            user_done_q   <= 1'b0;
        end else begin
            // any burned key bit locks the key
            if (mac_done && idx_q[6:4] == 3'h1 && mac_rdata != 8'h00) begin
                key_used_q <= 1'b1;
            end
            // any burned anchor bit locks the anchor
            if (mac_done && idx_q[6:5] == 2'h1 && mac_rdata != 8'h00) begin
                anchor_used_q <= 1'b1;
            end
            if (set_pg && hit[fuse_ctrl_pkg::RG_KEY]) begin
                key_used_q <= 1'b1;
            end
            if (set_pg && hit[fuse_ctrl_pkg::RG_ANCHOR]) begin
                anchor_used_q <= 1'b1;
            end
            if (set_pg && hit[fuse_ctrl_pkg::RG_USER]) begin
                user_done_q <= 1'b1;
            end
        end
    end

    // start bit
    // a start written during reload waits in the register and launches once
    // the sequencer reaches idle
    always_ff @(posedge clk) begin
        if (rst) begin
            operation_start_q <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::START_BIT];
        end else if (finish) begin
            // start drops with the ending flag
            operation_start_q <= 1'b0;
        end else if (wr_cs && wdata[fuse_ctrl_pkg::START_BIT]) begin
            operation_start_q <= 1'b1;
        end
    end

    // direction, address and size
    always_ff @(posedge clk) begin
        if (rst) begin
            operation_direction_q    <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::DIR_BIT];
            transfer_size_q          <= fuse_ctrl_pkg::ADDR_RST[fuse_ctrl_pkg::SIZE_LSB +: 6];
            transfer_start_address_q <= fuse_ctrl_pkg::ADDR_RST[fuse_ctrl_pkg::SADDR_LSB +: 7];
        end else begin
            if (wr_cs && !operation_start_q) begin
                operation_direction_q <= wdata[fuse_ctrl_pkg::DIR_BIT];
            end
            if (wr_addr && !operation_start_q) begin
                transfer_size_q          <= wdata[fuse_ctrl_pkg::SIZE_LSB +: 6];
                transfer_start_address_q <= wdata[fuse_ctrl_pkg::SADDR_LSB +: 7];
            end
        end
    end

    // interrupt enables
    // enables follow every control write, also while a sequence runs
    always_ff @(posedge clk) begin
        if (rst) begin
            read_done_irq_enable_q      <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::RD_IE_BIT];
            program_done_irq_enable_q   <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::PG_IE_BIT];
            boundary_error_irq_enable_q <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::BE_IE_BIT];
        end else if (wr_cs) begin
            read_done_irq_enable_q      <= wdata[fuse_ctrl_pkg::RD_IE_BIT];
            program_done_irq_enable_q   <= wdata[fuse_ctrl_pkg::PG_IE_BIT];
            boundary_error_irq_enable_q <= wdata[fuse_ctrl_pkg::BE_IE_BIT];
        end
    end

    // sticky flags, a set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            read_done_flag_q      <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::RD_FLAG_BIT];
            program_done_flag_q   <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::PG_FLAG_BIT];
            boundary_error_flag_q <= fuse_ctrl_pkg::CS_RST[fuse_ctrl_pkg::BE_FLAG_BIT];
        end else begin
            read_done_flag_q <= set_rd
                || (read_done_flag_q && !(wr_cs && wdata[fuse_ctrl_pkg::RD_CLR_BIT]));
            program_done_flag_q <= set_pg
                || (program_done_flag_q && !(wr_cs && wdata[fuse_ctrl_pkg::PG_CLR_BIT]));
            boundary_error_flag_q <= set_be
                || (boundary_error_flag_q && !(wr_cs && wdata[fuse_ctrl_pkg::BE_CLR_BIT]));
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (read_done_flag_q && read_done_irq_enable_q)
                || (program_done_flag_q && program_done_irq_enable_q)
                || (boundary_error_flag_q && boundary_error_irq_enable_q);
        end
    end

    // register read, data valid the cycle after the strobe
    // rdata holds its value between strobes; unmapped offsets return zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            rdata <= 32'h0000_0000;
            if (addr == fuse_ctrl_pkg::CS_OFF) begin
                rdata[fuse_ctrl_pkg::START_BIT]   <= operation_start_q;
                rdata[fuse_ctrl_pkg::DIR_BIT]     <= operation_direction_q;
                rdata[fuse_ctrl_pkg::PG_FLAG_BIT] <= program_done_flag_q;
                rdata[fuse_ctrl_pkg::RD_FLAG_BIT] <= read_done_flag_q;
                rdata[fuse_ctrl_pkg::BE_FLAG_BIT] <= boundary_error_flag_q;
                rdata[fuse_ctrl_pkg::PG_IE_BIT]   <= program_done_irq_enable_q;
                rdata[fuse_ctrl_pkg::RD_IE_BIT]   <= read_done_irq_enable_q;
                rdata[fuse_ctrl_pkg::BE_IE_BIT]   <= boundary_error_irq_enable_q;
            end else if (addr == fuse_ctrl_pkg::ADDR_OFF) begin
                rdata[fuse_ctrl_pkg::SIZE_LSB +: 6]  <= transfer_size_q;
                rdata[fuse_ctrl_pkg::SADDR_LSB +: 7] <= transfer_start_address_q;
            end else if (data_sel && word[4:3] != 2'b01) begin
                // trust anchor words read as zero on the bus
                for (int b = 0; b < 4; b++) begin
                    rdata[8*b +: 8] <= shadow[{word, 2'(b)}];
                end
            end
        end
    end

    // boot rom sees every byte
    // this port is the only path to the trust anchor; keep it off the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            rom_data <= 8'h00;
        end else begin
            rom_data <= shadow[rom_addr];
        end
    end
endmodule

// ---- sim/efuse_read_program_controller_properties.sv ----
// port-level assertions of the fuse controller
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
module efuse_read_program_controller_properties (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    // side outputs
    input wire logic [7:0]  rom_data,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence cs_rd;
        rd_en && addr == fuse_ctrl_pkg::CS_OFF;
    endsequence
    sequence clr_then_rd;
        wr_en && addr == fuse_ctrl_pkg::CS_OFF && wdata[26:24] == 3'h7 ##2 cs_rd;
    endsequence
    AST_RESET_QUIET: assert property ($fell(rst) |-> rdata == 32'h0 && irq == 1'b0 && rom_data == 8'h0)
        else $error("outputs not quiet after reset");
    AST_UNMAPPED_ZERO: assert property (rd_en && addr == 12'h00C |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    AST_ANCHOR_HIDDEN: assert property (rd_en && addr >= 12'h120 && addr <= 12'h13C |=> rdata == 32'h0)
        else $error("trust anchor visible on bus");
    AST_RDATA_HOLDS: assert property (!rd_en |=> $stable(rdata))
        else $error("read data moved without a read");
    AST_CS_RESERVED: assert property (cs_rd |=> rdata[31:27] == 5'h0 && !rdata[23] && !rdata[19] && rdata[15:2] == 14'h0)
        else $error("control reserved bits not zero");
    AST_ADDR_RESERVED: assert property (rd_en && addr == fuse_ctrl_pkg::ADDR_OFF |=> rdata[31:14] == 18'h0 && !rdata[7])
        else $error("address reserved bits not zero");
    AST_IRQ_MATCHES: assert property (cs_rd |=> irq == |(rdata[18:16] & rdata[22:20]))
        else $error("interrupt disagrees with flags and enables");
    AST_FLAGS_CLEAR: assert property (clr_then_rd |=> rdata[18:16] == 3'h0)
        else $error("flags survive their clear bits");
    AST_IRQ_FALL_CAUSE: assert property ($fell(irq) |-> $past(wr_en, 2) && $past(addr, 2) == fuse_ctrl_pkg::CS_OFF)
        else $error("interrupt fell without a control write");
endmodule
bind efuse_read_program_controller efuse_read_program_controller_properties u_props (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rom_data(rom_data), .irq(irq));

// ---- sim/reg_master.sv ----
// register-port master with one-cycle strobes
// assumes the slave returns read data in the cycle after the strobe
`timescale 1ns/10ps
module reg_master (
    // clock
    input  wire logic        clk,
    // register port
    output      logic [11:0] addr,
    output      logic [31:0] wdata,
    output      logic        wr_en,
    output      logic        rd_en,
    input  wire logic [31:0] rdata
);
    initial begin
        addr = 12'h000;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        wdata <= ~d;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        d = rdata;
    endtask
endmodule

// ---- sim/efuse_read_program_controller_tb.sv ----
// self-checking bench of the fuse controller against a byte image of the array
// assumes the array is blanked during the first reset
`timescale 1ns/10ps
module efuse_read_program_controller_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        blank_array = 1'b1;
    logic [6:0]  rom_addr = 7'h00;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata;
    logic [7:0]  rom_data;
    logic        irq;
    logic [7:0]  fm [128];
    logic [31:0] v;
    logic [6:0]  be_a [5] = '{7'h01, 7'h40, 7'h50, 7'h64, 7'h04};
    logic [5:0]  be_s [5] = '{6'h02, 6'h10, 6'h10, 6'h1E, 6'h0B};
    logic        be_d [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    int          error_cnt = 0;
    int          checks = 0;
    efuse_read_program_controller u_dut (.clk(clk), .rst(rst), .blank_array(blank_array), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rom_addr(rom_addr), .rom_data(rom_data),
        .irq(irq));
    reg_master u_master (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] expw(input int w);
        return {fm[4*w+3], fm[4*w+2], fm[4*w+1], fm[4*w]};
    endfunction
    task automatic start(input logic [6:0] a, input logic [5:0] sz, input logic [31:0] cs);
        u_master.wr(12'h000, 32'h0700_0000);
        u_master.wr(12'h004, {18'h0, sz, 1'b0, a});
        u_master.wr(12'h000, cs | 32'h1);
    endtask
    task automatic poll(input logic [31:0] exp);
        v = 32'h1;
        for (int i = 0; i < 2000 && v[0] !== 1'b0; i++)
            u_master.rd(12'h000, v);
        chk(v, exp);
        chk({31'h0, irq}, 32'h1);
    endtask
    task automatic complete_run;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hB866));
        for (int i = 0; i < 128; i++)
            fm[i] = 8'h00;
        repeat (4) @(posedge clk);
        blank_array <= 1'b0;
        @(posedge clk);
        rst <= 1'b0;
        repeat (500) @(posedge clk);
        u_master.rd(12'h000, v);
        chk(v, 32'h0);
        u_master.rd(12'h00C, v);
        chk(v, 32'h0);
        $display("test 1 done");
        for (int k = 0; k < 2; k++) begin
            v = $urandom & 32'hFF;
            fm[0] = fm[0] | v[7:0];
            u_master.wr(12'h100, v);
            start(7'h00, 6'h01, 32'h0010_0002);
            u_master.wr(12'h004, 32'h3F7F);
            u_master.wr(12'h000, 32'h0010_0000);
            u_master.rd(12'h004, v);
            chk(v, 32'h0000_0100);
            poll(32'h0011_0002);
            u_master.rd(12'h100, v);
            chk(v, expw(0));
        end
        u_master.wr(12'h000, 32'h0700_0002);
        u_master.rd(12'h000, v);
        chk(v, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0);
        $display("test 2 done");
        u_master.wr(12'h100, 32'hFFFF_FFFF);
        for (int k = 0; k < 5; k++) begin
            start(be_a[k], be_s[k], 32'h0040_0000 | {30'h0, be_d[k], 1'b0});
            poll(32'h0044_0000 | {30'h0, be_d[k], 1'b0});
        end
        for (int k = 0; k < 8; k++) begin
            v = $urandom;
            {fm[99+4*k], fm[98+4*k], fm[97+4*k], fm[96+4*k]} = v;
            u_master.wr(12'h160 + 12'(4*k), v);
        end
        start(7'h60, 6'h20, 32'h0010_0002);
        poll(32'h0011_0002);
        start(7'h60, 6'h20, 32'h0040_0002);
        poll(32'h0044_0002);
        $display("test 3 done");
        start(7'h00, 6'h04, 32'h0020_0000);
        poll(32'h0022_0000);
        u_master.rd(12'h100, v);
        chk(v, expw(0));
        u_master.rd(12'h120, v);
        chk(v, 32'h0);
        repeat (2) @(posedge clk);
        chk({24'h0, rom_data}, {24'h0, fm[0]});
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (500) @(posedge clk);
        for (int w = 0; w < 32; w++) begin
            u_master.rd(12'h100 + 12'(4*w), v);
            chk(v, (w >= 8 && w < 16) ? 32'h0 : expw(w));
        end
        start(7'h60, 6'h20, 32'h0010_0002);
        poll(32'h0011_0002);
        $display("test 4 done");
        complete_run();
    end
endmodule
